// >>> hdl/cpcr_pkg.sv
// Purpose: constants for the program sequencing and core register block
// Assumes: 8-bit core, 17-bit program counter plus bank flag, 9-bit data ram
// Notes:   offsets, reset values and vector layout live here only
// Operation
// - 17-bit program counter plus bank flag choosing one of two 128k banks
// - reset loads program counter 00000h and clears bank flag
// - interrupt clears bank flag; index 0-9 loads vector 00003h plus eight per index, higher keeps pc
// - ordinary instruction advances counter by its byte count, bank kept
// - jump/call absolute, relative pc+2+signed offset, accumulator call pc+1+a
// - taken conditional branch loads pc plus byte count plus signed
// - return takes pc high from ram(sp), low and bank from ram(sp-1)
// - call writes bank+pc low at sp+1, pc high at sp+2, sp+=2
// - data ram below fe00h is nine bits, ninth bit via status bit 1
// - bytes 0000h-007fh form 64 two-byte indirect registers, still ram
// - table lookup read uses indirect register as 17 bits (9+8)
// - accumulator at fe00h, cleared on reset
// - b pairs with accumulator for 16-bit ops, holds mul/div results
// - b supplies upper eight bits of the 24-bit external address
// - b register at fe01h, cleared on reset
// - c register is signed offset added to indirect register
// - c register at fe02h, cleared on reset
// - status word at fe06h, cleared; flags, ninth bit, lookup bank
// - lookup bank flag selects lower or upper program bank
// - parity bit always reflects odd ones count of accumulator
package cpcr_pkg;
  localparam int PC_W = 17;
  localparam logic [16:0] PC_RESET = 17'h00000;
  localparam logic [16:0] VEC_BASE = 17'h00003;
  localparam int VEC_STEP_SH = 3;
  localparam logic [3:0] VEC_LAST = 4'h9;
  localparam logic [15:0] ADDR_ACC = 16'hfe00;
  localparam logic [15:0] ADDR_B = 16'hfe01;
  localparam logic [15:0] ADDR_C = 16'hfe02;
  localparam logic [15:0] ADDR_PSW = 16'hfe06;
  localparam logic [15:0] RAM9_TOP = 16'hfdff;
  localparam logic [15:0] IREG_TOP = 16'h007f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_LKB = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P1 = 1;
  localparam int PSW_PAR = 0;
  typedef enum logic [3:0] {
    CPCR_OP_NONE, CPCR_OP_SEQ, CPCR_OP_JUMP, CPCR_OP_REL12, CPCR_OP_ACALL,
    CPCR_OP_COND, CPCR_OP_CALL, CPCR_OP_SHORT_RELATIVE_CALL, CPCR_OP_RET, CPCR_OP_IRQ
  } cpcr_op_type;
  typedef enum logic [1:0] {
    CPCR_ST_IDLE, CPCR_ST_PUSH_LO, CPCR_ST_PUSH_HI, CPCR_ST_POP_LO
  } cpcr_state_type;
endpackage

// >>> hdl/cpcr_parity.sv
// Purpose: parity of an 8-bit value
// Assumes: purely combinational
// Notes:   one when the count of ones is odd
`timescale 1ns/1ps
module cpcr_parity (
  input  wire logic [7:0] value,
  output logic            odd
);
  assign odd = ^value;
endmodule

// >>> hdl/cpcr_core.sv
// Purpose: program counter, bank flag, stack push/pop and core registers
// Assumes: instruction decode supplies one-cycle op pulses with operands
// Notes:   data-space accesses are one per cycle; ram is outside this block
`timescale 1ns/1ps
module cpcr_core
  import cpcr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire cpcr_pkg::cpcr_op_type      op,
  input  wire logic [2:0]                 op_nb,
  input  wire logic [16:0]                op_abs,
  input  wire logic [11:0]                op_r12,
  input  wire logic [7:0]                 op_r8,
  input  wire logic                       op_taken,
  input  wire logic [3:0]                 irq_index,
  input  wire logic                       ram_rd_valid,
  input  wire logic [8:0]                 ram_rd_data,
  input  wire logic                       dwr,
  input  wire logic                       drd,
  input  wire logic [15:0]                daddr,
  input  wire logic [7:0]                 dwdata,
  input  wire logic                       alu_we,
  input  wire logic [7:0]                 alu_acc,
  input  wire logic [7:0]                 alu_b,
  input  wire logic [7:0]                 alu_c,
  input  wire logic                       alu_b_we,
  input  wire logic                       alu_c_we,
  input  wire logic                       flags_we,
  input  wire logic                       flag_cy,
  input  wire logic                       flag_ac,
  input  wire logic                       flag_ov,
  input  wire logic [15:0]                ireg_value,
  input  wire logic                       ireg_ninth,
  input  wire logic                       ext_req,
  input  wire logic [15:0]                ext_low,
  output logic [16:0]                     pc,
  output logic                            program_bank_flag,
  output logic [15:0]                     stack_pointer,
  output logic                            ram_we,
  output logic                            ram_re,
  output logic [15:0]                     ram_addr,
  output logic [8:0]                      ram_wdata,
  output logic [7:0]                      drdata,
  output logic                            drd_is_core,
  output logic                            ram_ninth_bit_flag,
  output logic [17:0]                     lookup_addr,
  output logic [15:0]                     ofs_addr,
  output logic [23:0]                     ext_addr,
  output logic [15:0]                     acc_b_pair,
  output logic                            busy
);
  logic [16:0] pc_reg;
  logic        bank_reg;
  logic [15:0] sp_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  b_reg;
  logic [7:0]  c_reg;
  logic [7:0]  psw_reg;
  logic [16:0] ret_pc_reg;
  logic        ret_bank_reg;
  logic [8:0]  pop_hi_reg;
  logic        parity_next;
  logic        core_hit;
  logic [7:0]  core_rdata;
  cpcr_state_type state_reg;
  logic        busy_reg;
  logic        ram_we_reg;
  logic        ram_re_reg;
  logic [15:0] ram_addr_reg;
  logic [8:0]  ram_wdata_reg;
  logic [7:0]  drdata_reg;
  logic        drd_core_reg;
  logic [17:0] lookup_reg;
  logic [15:0] ofs_reg;
  logic [23:0] ext_reg;

  cpcr_parity u_parity (
    .value (acc_reg),
    .odd   (parity_next)
  );

  assign core_hit = (daddr == ADDR_ACC) || (daddr == ADDR_B) ||
                    (daddr == ADDR_C) || (daddr == ADDR_PSW);

  always_comb begin
    case (daddr)
      ADDR_ACC: core_rdata = acc_reg;
      ADDR_B:   core_rdata = b_reg;
      ADDR_C:   core_rdata = c_reg;
      ADDR_PSW: core_rdata = {psw_reg[7:1], parity_next};
      default:  core_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_reg   <= PC_RESET;
      bank_reg <= 1'b0;
    end else if (state_reg == CPCR_ST_POP_LO && ram_rd_valid &&
                 ram_addr_reg != sp_reg) begin
      // reload only on the low word, so pc never shows half an address
      pc_reg   <= {pop_hi_reg, ram_rd_data[7:0]};
      bank_reg <= ram_rd_data[8];
    end else if (state_reg == CPCR_ST_IDLE) begin
      case (op)
        CPCR_OP_SEQ:   pc_reg <= pc_reg + {14'h0000, op_nb};
        CPCR_OP_JUMP:  pc_reg <= op_abs;
        CPCR_OP_CALL:  pc_reg <= op_abs;
        CPCR_OP_REL12: pc_reg <= pc_reg + 17'h00002 + {{5{op_r12[11]}}, op_r12};
        CPCR_OP_SHORT_RELATIVE_CALL: pc_reg <= pc_reg + 17'h00002 + {{5{op_r12[11]}}, op_r12};
        CPCR_OP_ACALL: pc_reg <= pc_reg + 17'h00001 + {9'h000, acc_reg};
        CPCR_OP_COND: begin
          if (op_taken) begin
            pc_reg <= pc_reg + {14'h0000, op_nb} + {{9{op_r8[7]}}, op_r8};
          end else begin
            pc_reg <= pc_reg + {14'h0000, op_nb};
          end
        end
        CPCR_OP_IRQ: begin
          if (irq_index <= VEC_LAST) begin
            pc_reg <= VEC_BASE + (17'(irq_index) << VEC_STEP_SH);
          end
          bank_reg <= 1'b0;
        end
        default: pc_reg <= pc_reg;
      endcase
    end
  end

  // return address latched at the op edge; the push starts one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_pc_reg <= PC_RESET;
    end else if (state_reg == CPCR_ST_IDLE) begin
      case (op)
        CPCR_OP_CALL:  ret_pc_reg <= pc_reg + {14'h0000, op_nb};
        CPCR_OP_SHORT_RELATIVE_CALL: ret_pc_reg <= pc_reg + 17'h00002;
        CPCR_OP_ACALL: ret_pc_reg <= pc_reg + 17'h00001;
        CPCR_OP_IRQ:   ret_pc_reg <= pc_reg;
        default:       ret_pc_reg <= ret_pc_reg;
      endcase
    end
  end

  // bank pushed with low byte, taken before an entry clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_bank_reg <= 1'b0;
    end else if (state_reg == CPCR_ST_IDLE) begin
      ret_bank_reg <= bank_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= CPCR_ST_IDLE;
      sp_reg        <= SP_RESET;
      ram_we_reg    <= 1'b0;
      ram_re_reg    <= 1'b0;
      ram_addr_reg  <= SP_RESET;
      ram_wdata_reg <= 9'h000;
      pop_hi_reg    <= 9'h000;
      busy_reg      <= 1'b0;
    end else begin
      ram_we_reg <= 1'b0;
      ram_re_reg <= 1'b0;
      case (state_reg)
        CPCR_ST_IDLE: begin
          if (op == CPCR_OP_CALL || op == CPCR_OP_SHORT_RELATIVE_CALL ||
              op == CPCR_OP_ACALL || op == CPCR_OP_IRQ) begin
            state_reg <= CPCR_ST_PUSH_LO;
            busy_reg  <= 1'b1;
          end else if (op == CPCR_OP_RET) begin
            ram_re_reg   <= 1'b1;
            ram_addr_reg <= sp_reg;
            state_reg    <= CPCR_ST_POP_LO;
            busy_reg     <= 1'b1;
          end
        end
        CPCR_ST_PUSH_LO: begin
          ram_we_reg    <= 1'b1;
          ram_addr_reg  <= sp_reg + 16'h0001;
          ram_wdata_reg <= {ret_bank_reg, ret_pc_reg[7:0]};
          state_reg     <= CPCR_ST_PUSH_HI;
        end
        CPCR_ST_PUSH_HI: begin
          ram_we_reg    <= 1'b1;
          ram_addr_reg  <= sp_reg + 16'h0002;
          ram_wdata_reg <= ret_pc_reg[16:8];
          sp_reg        <= sp_reg + 16'h0002;
          busy_reg      <= 1'b0;
          state_reg     <= CPCR_ST_IDLE;
        end
        CPCR_ST_POP_LO: begin
          if (ram_rd_valid && ram_addr_reg == sp_reg) begin
            pop_hi_reg   <= ram_rd_data;
            ram_re_reg   <= 1'b1;
            ram_addr_reg <= sp_reg - 16'h0001;
          end else if (ram_rd_valid) begin
            sp_reg    <= sp_reg - 16'h0002;
            busy_reg  <= 1'b0;
            state_reg <= CPCR_ST_IDLE;
          end
        end
        default: begin
          state_reg <= CPCR_ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= REG_RESET;
    end else if (alu_we) begin
      // alu result wins over a data-space write
      acc_reg <= alu_acc;
    end else if (dwr && daddr == ADDR_ACC) begin
      acc_reg <= dwdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_reg <= REG_RESET;
    end else if (alu_b_we) begin
      b_reg <= alu_b;
    end else if (dwr && daddr == ADDR_B) begin
      b_reg <= dwdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg <= REG_RESET;
    end else if (alu_c_we) begin
      c_reg <= alu_c;
    end else if (dwr && daddr == ADDR_C) begin
      c_reg <= dwdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psw_reg <= REG_RESET;
    end else begin
      // a status write overrides the flag strobes of the same cycle
      if (dwr && daddr == ADDR_PSW) begin
        psw_reg <= dwdata;
      end else if (flags_we) begin
        psw_reg[PSW_CY] <= flag_cy;
        psw_reg[PSW_AC] <= flag_ac;
        psw_reg[PSW_OV] <= flag_ov;
      end
      // ninth bit captured on ram read
      if (drd && daddr <= RAM9_TOP && ram_rd_valid) begin
        psw_reg[PSW_P1] <= ram_rd_data[8];
      end
      psw_reg[PSW_PAR] <= parity_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drd_core_reg <= 1'b0;
    end else begin
      drd_core_reg <= drd && core_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drdata_reg <= REG_RESET;
    end else if (drd && core_hit) begin
      drdata_reg <= core_rdata;
    end
  end

  // lookup address with bank
  // addresses are registered, so they trail their operands by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lookup_reg <= 18'h00000;
    end else begin
      lookup_reg <= {psw_reg[PSW_LKB], ireg_ninth, ireg_value};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ofs_reg <= 16'h0000;
    end else begin
      ofs_reg <= ireg_value + {{8{c_reg[7]}}, c_reg};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_reg <= 24'h000000;
    end else if (ext_req) begin
      ext_reg <= {b_reg, ext_low};
    end
  end

  assign pc                 = pc_reg;
  assign program_bank_flag  = bank_reg;
  assign stack_pointer      = sp_reg;
  assign ram_we             = ram_we_reg;
  assign ram_re             = ram_re_reg;
  assign ram_addr           = ram_addr_reg;
  assign ram_wdata          = ram_wdata_reg;
  assign drdata             = drdata_reg;
  assign drd_is_core        = drd_core_reg;
  assign ram_ninth_bit_flag = psw_reg[PSW_P1];
  assign lookup_addr        = lookup_reg;
  assign ofs_addr           = ofs_reg;
  assign ext_addr           = ext_reg;
  assign acc_b_pair         = {b_reg, acc_reg};
  assign busy               = busy_reg;
endmodule

// >>> verif/cpcr_assertions.sv
// Purpose: port checks for cpcr_core
// Assumes: one clock, rst async high
// Notes:   bound below to every cpcr_core
`timescale 1ns/1ps
module cpcr_assertions
  import cpcr_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire cpcr_pkg::cpcr_op_type op,
  input wire logic [2:0]           op_nb,
  input wire logic [16:0]          op_abs,
  input wire logic [3:0]           irq_index,
  input wire logic                 busy,
  input wire logic [16:0]          pc,
  input wire logic                 program_bank_flag,
  input wire logic [15:0]          stack_pointer,
  input wire logic                 ram_we,
  input wire logic                 ram_re,
  input wire logic [15:0]          ram_addr,
  input wire logic                 drd,
  input wire logic [15:0]          daddr,
  input wire logic                 drd_is_core,
  input wire logic [15:0]          ireg_value,
  input wire logic                 ireg_ninth,
  input wire logic [17:0]          lookup_addr,
  input wire logic                 ext_req,
  input wire logic [15:0]          ext_low,
  input wire logic [23:0]          ext_addr,
  input wire logic [15:0]          acc_b_pair
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_seq;
    op == CPCR_OP_SEQ && !busy |=> pc == $past(pc) + 17'($past(op_nb))
      && $stable(program_bank_flag);
  endproperty
  a_seq: assert property (p_seq) else $error("pc step wrong");
  property p_jump;
    (op == CPCR_OP_JUMP || op == CPCR_OP_CALL) && !busy |=> pc == $past(op_abs);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_irq;
    op == CPCR_OP_IRQ && !busy && irq_index < 4'ha |=> !program_bank_flag
      && pc == VEC_BASE + {$past(irq_index), 3'h0};
  endproperty
  a_irq: assert property (p_irq) else $error("vector wrong");
  property p_push;
    op == CPCR_OP_CALL && !busy |-> ##[2:4] ram_we && ram_addr == stack_pointer + 16'h1;
  endproperty
  a_push: assert property (p_push) else $error("push slot wrong");
  property p_pop;
    ram_re |-> ram_addr == stack_pointer || ram_addr == stack_pointer - 16'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop slot wrong");
  property p_core;
    drd && (daddr == ADDR_ACC || daddr == ADDR_PSW) |=> drd_is_core;
  endproperty
  a_core: assert property (p_core) else $error("core read missed");
  property p_ext;
    ext_req |=> ext_addr == {$past(acc_b_pair[15:8]), $past(ext_low)};
  endproperty
  a_ext: assert property (p_ext) else $error("external address wrong");
  property p_lkp;
    lookup_addr[16:0] == $past({ireg_ninth, ireg_value});
  endproperty
  a_lkp: assert property (p_lkp) else $error("lookup address wrong");
  c_call: cover property (op == CPCR_OP_CALL && !busy);
  c_ret: cover property (ram_re ##[1:8] ram_re);
  c_core: cover property (drd_is_core);
endmodule
bind cpcr_core cpcr_assertions chk_u (.*);

// >>> verif/cpcr_ram_model.sv
// Purpose: data ram behind the stack port
// Assumes: reads answered after one or four cycles
// Notes:   idle read data toggles so stale words never pass
`timescale 1ns/1ps
module cpcr_ram_model (
  input wire logic        clk,
  input wire logic        slow,
  input wire logic        ram_we,
  input wire logic        ram_re,
  input wire logic [15:0] ram_addr,
  input wire logic [8:0]  ram_wdata,
  output logic            ram_rd_valid,
  output logic [8:0]      ram_rd_data
);
  logic [8:0]  mem [logic [15:0]];
  logic [15:0] pend;
  int          cnt = -1;
  initial ram_rd_valid = 1'b0;
  initial ram_rd_data = 9'h0;
  always @(posedge clk) begin
    ram_rd_valid <= 1'b0;
    ram_rd_data <= ~ram_rd_data;
    if (ram_we) mem[ram_addr] = ram_wdata;
    if (ram_re) begin
      pend <= ram_addr;
      cnt <= slow ? 3 : 0;
    end else if (cnt == 0) begin
      ram_rd_valid <= 1'b1;
      ram_rd_data <= mem.exists(pend) ? mem[pend] : 9'h0;
      cnt <= -1;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

// >>> verif/test_cpcr_core.sv
// Purpose: self-checking bench for cpcr_core
// Assumes: ram model answers stack reads
// Notes:   alu and flag strobes pulsed once near the end
`timescale 1ns/1ps
module test_cpcr_core;
  import cpcr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, op_taken = 1'b0, dwr = 1'b0, drd = 1'b0;
  logic ireg_ninth = 1'b0, eb = 1'b0, flag_cy = 1'b0, flag_ac = 1'b0, flag_ov = 1'b0;
  logic alu_we = 1'b0, alu_b_we = 1'b0, alu_c_we = 1'b0, flags_we = 1'b0, ext_req = 1'b0;
  cpcr_op_type op = CPCR_OP_NONE;
  logic [2:0] op_nb = 3'h0;
  logic [3:0] irq_index = 4'h0;
  logic [11:0] op_r12 = 12'h0;
  logic [16:0] op_abs = 17'h0, ep = 17'h0, t, pc;
  logic [7:0] op_r8 = 8'h0, dwdata = 8'h0, alu_acc = 8'h0, alu_b = 8'h0, alu_c = 8'h0;
  logic [7:0] seed = 8'h16, a, b, c, p, drdata;
  logic [15:0] daddr = 16'h0, ireg_value = 16'h0, ext_low = 16'h0;
  logic program_bank_flag, ram_we, ram_re, ram_rd_valid, drd_is_core, ram_ninth_bit_flag, busy;
  logic [15:0] stack_pointer, ram_addr, ofs_addr, acc_b_pair;
  logic [8:0] ram_wdata, ram_rd_data;
  logic [17:0] lookup_addr;
  logic [23:0] ext_addr;
  logic [7:0] exp_q [$];
  int err_count = 0, n_compared = 0;
  cpcr_core dut_u (.*);
  cpcr_ram_model ram_u (.*);
  always #10 clk = ~clk;
  task nx(output logic [7:0] v);
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    v = seed;
  endtask
  task chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rd(input logic [15:0] ad, input logic [7:0] e, input logic core);
    @(posedge clk);
    #1 drd = 1'b1;
    daddr = ad;
    if (core) exp_q.push_back(e);
    @(posedge clk);
    #1 drd = 1'b0;
  endtask
  task wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    #1 dwr = 1'b1;
    daddr = ad;
    dwdata = d;
    @(posedge clk);
    #1 dwr = 1'b0;
  endtask
  task do_op(input cpcr_op_type o, input logic [16:0] e_pc, input logic e_bk);
    int n;
    @(posedge clk);
    #1 op = o;
    @(posedge clk);
    #1 op = CPCR_OP_NONE;
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk({program_bank_flag, pc}, {e_bk, e_pc});
    ep = e_pc;
    eb = e_bk;
  endtask
  always @(posedge clk) begin
    if (drd_is_core === 1'b1) begin
      if (exp_q.size() == 0) chk(18'h3ffff, 18'h0);
      else chk({10'h0, drdata}, {10'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk({program_bank_flag, pc}, 18'h0);
    rd(ADDR_ACC, 8'h0, 1'b1);
    rd(ADDR_B, 8'h0, 1'b1);
    rd(ADDR_C, 8'h0, 1'b1);
    rd(ADDR_PSW, 8'h0, 1'b1);
    nx(a); nx(b); nx(c); nx(p);
    {alu_acc, alu_b, alu_c, flag_cy, flag_ac, flag_ov} = {c, a, b, p[2:0]};
    {ireg_value, ext_low, ireg_ninth} = {a, p, c, b, p[0]};
    ext_req = 1'b1;
    wr(ADDR_ACC, a); wr(ADDR_B, b); wr(ADDR_C, c); wr(ADDR_PSW, p);
    // registered addresses follow their sources one edge later
    @(posedge clk);
    #1;
    chk({17'h0, ram_ninth_bit_flag}, {17'h0, p[1]});
    chk({17'h0, lookup_addr[17]}, {17'h0, p[3]});
    chk({2'h0, acc_b_pair}, {2'h0, b, a});
    chk({10'h0, ext_addr[23:16]}, {10'h0, b});
    chk({2'h0, ofs_addr}, {2'h0, ireg_value + {{8{c[7]}}, c}});
    rd(ADDR_ACC, a, 1'b1);
    rd(ADDR_B, b, 1'b1);
    rd(ADDR_C, c, 1'b1);
    rd(ADDR_PSW, {p[7:1], ^a}, 1'b1);
    rd(16'hfe03, 8'h0, 1'b0);
    rd(16'h0010, 8'h0, 1'b0);
    op_nb = 3'h3;
    do_op(CPCR_OP_SEQ, ep + 17'h3, eb);
    op_abs = {1'b1, a, b}; // target kept clear of the option block
    do_op(CPCR_OP_JUMP, op_abs, eb);
    op_r12 = 12'h800;
    do_op(CPCR_OP_REL12, ep + 17'h2 - 17'h800, eb);
    op_r12 = 12'h7ff;
    do_op(CPCR_OP_REL12, ep + 17'h801, eb);
    op_nb = 3'h2;
    op_r8 = 8'h80;
    op_taken = 1'b1;
    do_op(CPCR_OP_COND, ep + 17'h2 - 17'h80, eb);
    op_r8 = 8'h7f;
    do_op(CPCR_OP_COND, ep + 17'h81, eb);
    op_taken = 1'b0;
    do_op(CPCR_OP_COND, ep + 17'h2, eb);
    t = ep + 17'h1;
    do_op(CPCR_OP_ACALL, t + {9'h0, a}, eb);
    do_op(CPCR_OP_RET, t, 1'b0);
    ram_u.mem[16'h0000] = {1'b1, c};
    ram_u.mem[16'hffff] = {1'b1, b};
    slow = 1'b1;
    do_op(CPCR_OP_RET, {1'b1, c, b}, 1'b1);
    do_op(CPCR_OP_CALL, op_abs, 1'b1);
    do_op(CPCR_OP_IRQ, VEC_BASE, 1'b0);
    do_op(CPCR_OP_RET, op_abs, 1'b1);
    irq_index = 4'ha;
    do_op(CPCR_OP_IRQ, op_abs, 1'b0);
    for (int i = 1; i < 10; i++) begin
      irq_index = 4'(i);
      do_op(CPCR_OP_IRQ, VEC_BASE + 17'(i * 8), 1'b0);
    end
    @(posedge clk);
    #1 {alu_we, alu_b_we, alu_c_we, flags_we} = 4'hf;
    @(posedge clk);
    #1 {alu_we, alu_b_we, alu_c_we, flags_we} = 4'h0;
    rd(ADDR_ACC, c, 1'b1);
    rd(ADDR_B, a, 1'b1);
    rd(ADDR_C, b, 1'b1);
    rd(ADDR_PSW, {p[2:1], p[5:3], p[0], p[1], ^c}, 1'b1);
    @(posedge clk);
    #1 chk({2'h0, stack_pointer}, 18'h14);
    chk(18'(exp_q.size()), 18'h0);
    results();
  end
endmodule
